//--- core/core_config_defines.svh
// Purpose: bit positions, masks and reset values of core_config_one
// Assumes: fields numbered with bit 0 as the most significant bit
// Notes:   vectors in the design are declared [0:31] to match
`ifndef CORE_CONFIG_DEFINES_SVH
`define CORE_CONFIG_DEFINES_SVH

`define CFG_WIDTH            32
`define CFG_RESET            32'h0000_0000
// writable bits: 0..20 and 24; 21..23 and 25..31 stay zero
`define CFG_WRITE_MASK       32'hFFFF_F880
`define ICD_PAR_LO           0
`define ICD_PAR_HI           7
`define ICT_PAR_LO           8
`define ICT_PAR_HI           9
`define DCT_PAR_LO           10
`define DCT_PAR_HI           11
`define DCD_PAR_BIT          12
`define DCU_PAR_BIT          13
`define DCM_PAR_BIT          14
`define FORCE_MISS_BIT       15
`define MMU_PAR_LO           16
`define MMU_PAR_HI           19
`define WHOLE_FLUSH_BIT      20
`define TIMER_SEL_BIT        24
`define LINE_DWORDS          4
`define TIMER_WIDTH          64

`endif

//--- core/core_config_pkg.sv
// Purpose: shared types of the core configuration block
// Assumes: nothing
// Notes:   encodings written out in binary
package core_config_pkg;

   typedef enum logic [1:0] {
      FLUSH_NONE  = 2'b00,
      FLUSH_DWORD = 2'b01,
      FLUSH_QWORD = 2'b10,
      FLUSH_LINE  = 2'b11
   } flush_size_t;

   typedef enum logic [1:0] {
      SPR_IDLE = 2'b00,
      SPR_READ = 2'b01,
      SPR_WRITE = 2'b10,
      SPR_FAULT = 2'b11
   } spr_op_t;

endpackage

//--- core/timer_tick_if.sv
// Purpose: carries the alternate timer clock edge into the core domain
// Assumes: single core clock
// Notes:   tick is a one-cycle pulse per rising edge of the alternate clock
`timescale 1ns/1ps
interface timer_tick_if;
   logic tick;
   modport source (output tick);
   modport sink   (input  tick);
endinterface

//--- core/timer_edge_sync.sv
// Purpose: synchronise alt_timer_clock and detect its rising edges
// Assumes: alt_timer_clock toggles at most at half the core clock rate
// Notes:   the first stage feeds only the second stage
`timescale 1ns/1ps
module timer_edge_sync (
   // clock and reset
   input  wire logic       clk,
   input  wire logic       rst,
   // asynchronous timer clock pin
   input  wire logic       alt_timer_clock,
   // edge pulse toward the timer
   timer_tick_if.source    tick_port
);

   logic meta_ff;
   logic sync_ff;
   logic prev_ff;
   logic tick_ff;
   logic nxt_tick;

   always_comb begin
      nxt_tick = sync_ff & ~prev_ff;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_ff <= 1'b0;
         sync_ff <= 1'b0;
         prev_ff <= 1'b0;
         tick_ff <= 1'b0;
      end else begin
         meta_ff <= alt_timer_clock;
         sync_ff <= meta_ff;
         prev_ff <= sync_ff;
         tick_ff <= nxt_tick;
      end
   end

   assign tick_port.tick = tick_ff;

endmodule

//--- core/core_config_parity_inject_reg.sv
// Purpose: core_config_one register and the logic it steers
// Assumes: one core clock; cache and mmu parity computed by the caller
// Notes:   all outputs registered, so effects show one cycle after inputs; alt_timer_clock reaches cpu_timer on the fourth edge
`timescale 1ns/1ps
`include "core_config_defines.svh"
module core_config_parity_inject_reg
   import core_config_pkg::*;
#(
   parameter int TIMER_W = `TIMER_WIDTH
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // special register moves
   input  wire logic                spr_write,
   input  wire logic                spr_read,
   input  wire logic [0:31]         spr_wdata,
   input  wire logic                user_mode_flag,
   output logic [0:31]              spr_rdata,
   output logic                     spr_rvalid,
   output logic                     priv_fault,
   // parity computed by the arrays, even parity
   input  wire logic [0:7]          icache_word_par,
   input  wire logic [0:1]          icache_tag_par,
   input  wire logic [0:1]          dcache_tag_par,
   input  wire logic                dcache_data_par,
   input  wire logic                dcache_uattr_par,
   input  wire logic                dcache_dirty_par,
   input  wire logic [0:3]          mmu_tag_par,
   // parity to record
   output logic [0:7]               icache_word_par_rec,
   output logic [0:1]               icache_tag_par_rec,
   output logic [0:1]               dcache_tag_par_rec,
   output logic                     dcache_data_par_rec,
   output logic                     dcache_uattr_par_rec,
   output logic                     dcache_dirty_par_rec,
   output logic [0:3]               mmu_tag_par_rec,
   // cache management lookup
   input  wire logic                cacheop_mgmt,
   input  wire logic                cacheop_hit,
   output logic                     cacheop_hit_eff,
   // dirty indicators, one per doubleword of the line
   input  wire logic [0:3]          line_dirty,
   output logic [0:3]               line_dirty_eff,
   output flush_size_t              flush_size,
   // timer
   input  wire logic                alt_timer_clock,
   output logic [TIMER_W-1:0]       cpu_timer
);

   ////////////////////////////////////////////////////////////////////////
   // register access

   logic [0:31]     cfg_ff;
   logic [0:31]     nxt_cfg;
   logic [0:31]     rdata_ff;
   logic [0:31]     nxt_rdata;
   logic            rvalid_ff;
   logic            fault_ff;
   spr_op_t         op;

   always_comb begin
      if ((spr_write | spr_read) & user_mode_flag) begin
         op = SPR_FAULT;
      end else if (spr_write) begin
         op = SPR_WRITE;
      end else if (spr_read) begin
         op = SPR_READ;
      end else begin
         op = SPR_IDLE;
      end
      nxt_cfg   = cfg_ff;
      nxt_rdata = rdata_ff;
      case (op)
         SPR_WRITE: begin
            nxt_cfg = spr_wdata & `CFG_WRITE_MASK;
         end
         SPR_READ: begin
            nxt_rdata = cfg_ff & `CFG_WRITE_MASK;
         end
         SPR_FAULT: begin
            nxt_cfg = cfg_ff;
         end
         default: begin
            nxt_cfg = cfg_ff;
         end
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff    <= `CFG_RESET;
         rdata_ff  <= 32'h0000_0000;
         rvalid_ff <= 1'b0;
         fault_ff  <= 1'b0;
      end else begin
         cfg_ff    <= nxt_cfg;
         rdata_ff  <= nxt_rdata;
         rvalid_ff <= (op == SPR_READ);
         fault_ff  <= (op == SPR_FAULT);
      end
   end

   assign spr_rdata  = rdata_ff;
   assign spr_rvalid = rvalid_ff;
   assign priv_fault = fault_ff;

   ////////////////////////////////////////////////////////////////////////
   // parity insertion: xor with a set bit turns even parity into odd

   logic [0:7] nxt_icw;
   logic [0:1] nxt_ict;
   logic [0:1] nxt_dct;
   logic       nxt_dcd;
   logic       nxt_dcu;
   logic       nxt_dcm;
   logic [0:3] nxt_mmu;
   logic [0:7] icw_ff;
   logic [0:1] ict_ff;
   logic [0:1] dct_ff;
   logic       dcd_ff;
   logic       dcu_ff;
   logic       dcm_ff;
   logic [0:3] mmu_ff;

   always_comb begin
      nxt_icw = icache_word_par
              ^ cfg_ff[`ICD_PAR_LO:`ICD_PAR_HI];
      nxt_ict = icache_tag_par
              ^ cfg_ff[`ICT_PAR_LO:`ICT_PAR_HI];
      nxt_dct = dcache_tag_par
              ^ cfg_ff[`DCT_PAR_LO:`DCT_PAR_HI];
      nxt_dcd = dcache_data_par ^ cfg_ff[`DCD_PAR_BIT];
      nxt_dcu = dcache_uattr_par ^ cfg_ff[`DCU_PAR_BIT];
      nxt_dcm = dcache_dirty_par ^ cfg_ff[`DCM_PAR_BIT];
      nxt_mmu = mmu_tag_par
              ^ cfg_ff[`MMU_PAR_LO:`MMU_PAR_HI];
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         icw_ff <= 8'h00;
         ict_ff <= 2'h0;
         dct_ff <= 2'h0;
         dcd_ff <= 1'b0;
         dcu_ff <= 1'b0;
         dcm_ff <= 1'b0;
         mmu_ff <= 4'h0;
      end else begin
         icw_ff <= nxt_icw;
         ict_ff <= nxt_ict;
         dct_ff <= nxt_dct;
         dcd_ff <= nxt_dcd;
         dcu_ff <= nxt_dcu;
         dcm_ff <= nxt_dcm;
         mmu_ff <= nxt_mmu;
      end
   end

   assign icache_word_par_rec  = icw_ff;
   assign icache_tag_par_rec   = ict_ff;
   assign dcache_tag_par_rec   = dct_ff;
   assign dcache_data_par_rec  = dcd_ff;
   assign dcache_uattr_par_rec = dcu_ff;
   assign dcache_dirty_par_rec = dcm_ff;
   assign mmu_tag_par_rec      = mmu_ff;

   ////////////////////////////////////////////////////////////////////////
   // forced miss and flush sizing

   logic        nxt_hit;
   logic        hit_ff;
   logic [0:3]  nxt_dirty;
   logic [0:3]  dirty_ff;
   flush_size_t nxt_flush;
   flush_size_t flush_ff;

   always_comb begin
      // only management operations are forced; normal accesses still hit
      nxt_hit = cacheop_hit
              & ~(cacheop_mgmt & cfg_ff[`FORCE_MISS_BIT]);
      if (cfg_ff[`WHOLE_FLUSH_BIT]) begin
         nxt_dirty = {`LINE_DWORDS{|line_dirty}};
      end else begin
         nxt_dirty = line_dirty;
      end
      // a lone doubleword writes a dword, within one half a qword
      if (nxt_dirty == 4'h0) begin
         nxt_flush = FLUSH_NONE;
      end else if ((nxt_dirty == 4'h8) || (nxt_dirty == 4'h4)
                || (nxt_dirty == 4'h2) || (nxt_dirty == 4'h1)) begin
         nxt_flush = FLUSH_DWORD;
      end else if ((nxt_dirty[2:3] == 2'h0)
                || (nxt_dirty[0:1] == 2'h0)) begin
         nxt_flush = FLUSH_QWORD;
      end else begin
         nxt_flush = FLUSH_LINE;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hit_ff   <= 1'b0;
         dirty_ff <= 4'h0;
         flush_ff <= FLUSH_NONE;
      end else begin
         hit_ff   <= nxt_hit;
         dirty_ff <= nxt_dirty;
         flush_ff <= nxt_flush;
      end
   end

   assign cacheop_hit_eff = hit_ff;
   assign line_dirty_eff  = dirty_ff;
   assign flush_size      = flush_ff;

   ////////////////////////////////////////////////////////////////////////
   // cpu timer

   timer_tick_if tick_bus ();

   // the pin clock is only ever sampled, never used as a clock,
   // which is why it may toggle at most at half the core rate
   timer_edge_sync u_tick (
      .clk             (clk),
      .rst             (rst),
      .alt_timer_clock (alt_timer_clock),
      .tick_port       (tick_bus.source)
   );

   logic [TIMER_W-1:0] timer_ff;
   logic [TIMER_W-1:0] nxt_timer;

   always_comb begin
      nxt_timer = timer_ff;
      if (!cfg_ff[`TIMER_SEL_BIT]) begin
         nxt_timer = timer_ff + 1'b1;
      end else if (tick_bus.tick) begin
         nxt_timer = timer_ff + 1'b1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         timer_ff <= '0;
      end else begin
         timer_ff <= nxt_timer;
      end
   end

   assign cpu_timer = timer_ff;

endmodule

//--- testbench/core_config_chk.sv
// Purpose: port-level checker for core_config_parity_inject_reg
// Assumes: one clock domain, async active-high reset
// Notes:   shadow copy of the register is rebuilt from legal writes
`timescale 1ns/1ps
`include "core_config_defines.svh"
module core_config_chk
   import core_config_pkg::*;
#(
   parameter int TIMER_W = 64
) (
   // clock and reset
   input wire logic               clk,
   input wire logic               rst,
   // register moves
   input wire logic               spr_write,
   input wire logic               spr_read,
   input wire logic [0:31]        spr_wdata,
   input wire logic               user_mode_flag,
   input wire logic [0:31]        spr_rdata,
   input wire logic               spr_rvalid,
   input wire logic               priv_fault,
   // parity
   input wire logic [0:7]         icache_word_par,
   input wire logic [0:7]         icache_word_par_rec,
   input wire logic [0:3]         mmu_tag_par,
   input wire logic [0:3]         mmu_tag_par_rec,
   // cache and flush
   input wire logic               cacheop_mgmt,
   input wire logic               cacheop_hit,
   input wire logic               cacheop_hit_eff,
   input wire logic [0:3]         line_dirty,
   input wire logic [0:3]         line_dirty_eff,
   input wire flush_size_t        flush_size,
   // timer
   input wire logic               alt_timer_clock,
   input wire logic [TIMER_W-1:0] cpu_timer
);
   logic [0:31] cfg_ff, nxt_cfg;
   logic        live_ff, alt_ff;
   logic [2:0]  quiet_ff, nxt_quiet;
   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_cfg = cfg_ff;
      if (spr_write && !user_mode_flag) begin
         nxt_cfg = spr_wdata & `CFG_WRITE_MASK;
      end
      // saturate so a long quiet pin keeps the check armed
      nxt_quiet = (alt_timer_clock != alt_ff) ? 3'h0 :
                  (quiet_ff == 3'h7) ? 3'h7 : quiet_ff + 3'h1;
   end
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         cfg_ff   <= '0;
         live_ff  <= 1'b0;
         alt_ff   <= 1'b0;
         quiet_ff <= 3'h0;
      end else begin
         cfg_ff   <= nxt_cfg;
         live_ff  <= 1'b1;
         alt_ff   <= alt_timer_clock;
         quiet_ff <= nxt_quiet;
      end
   end
   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   read_answer_a: assert property (
      spr_read && !spr_write && !user_mode_flag |=> spr_rvalid && !priv_fault)
      else $error("legal read not answered");
   user_refused_a: assert property (
      (spr_read || spr_write) && user_mode_flag
      |=> priv_fault && !spr_rvalid && $stable(spr_rdata))
      else $error("user access not refused");
   read_value_a: assert property (
      spr_rvalid |-> spr_rdata == $past(cfg_ff))
      else $error("read data differs from register");
   icache_par_a: assert property (
      live_ff |-> icache_word_par_rec == $past(icache_word_par ^ cfg_ff[0:7]))
      else $error("icache word parity wrong");
   mmu_par_a: assert property (
      live_ff |-> mmu_tag_par_rec == $past(mmu_tag_par ^ cfg_ff[16:19]))
      else $error("mmu tag parity wrong");
   forced_miss_a: assert property (
      live_ff |-> cacheop_hit_eff ==
         $past(cacheop_hit && !(cacheop_mgmt && cfg_ff[15])))
      else $error("effective hit wrong");
   dirty_eff_a: assert property (
      live_ff |-> line_dirty_eff == ($past(cfg_ff[20]) ?
         {4{$past(|line_dirty)}} : $past(line_dirty)))
      else $error("effective dirty wrong");
   whole_flush_a: assert property (
      live_ff && $past(cfg_ff[20])
      |-> flush_size inside {FLUSH_NONE, FLUSH_LINE})
      else $error("partial flush with whole-line set");
   core_tick_a: assert property (
      live_ff && !$past(cfg_ff[24]) |-> cpu_timer == $past(cpu_timer) + 1)
      else $error("timer missed core tick");
   alt_idle_a: assert property (
      live_ff && $past(cfg_ff[24]) && quiet_ff == 3'h7 |-> $stable(cpu_timer))
      else $error("timer moved with quiet pin");
   alt_step_a: assert property (
      live_ff && $past(cfg_ff[24]) |-> (cpu_timer == $past(cpu_timer))
         || (cpu_timer == $past(cpu_timer) + 1))
      else $error("timer stepped by more than one");
endmodule
bind core_config_parity_inject_reg core_config_chk #(.TIMER_W(TIMER_W))
   core_config_chk_i (.clk, .rst, .spr_write, .spr_read, .spr_wdata,
   .user_mode_flag, .spr_rdata, .spr_rvalid, .priv_fault, .icache_word_par,
   .icache_word_par_rec, .mmu_tag_par, .mmu_tag_par_rec, .cacheop_mgmt,
   .cacheop_hit, .cacheop_hit_eff, .line_dirty, .line_dirty_eff, .flush_size,
   .alt_timer_clock, .cpu_timer);

//--- testbench/tb.sv
// Purpose: self-checking bench for core_config_parity_inject_reg
// Assumes: inputs change on the falling edge, outputs one cycle late
// Notes:   expected values come from the field layout only
`timescale 1ns/1ps
`include "core_config_defines.svh"
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
   $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module tb;
   import core_config_pkg::*;
   logic        clk = 0, rst = 1;
   logic        spr_write = 0, spr_read = 0, user_mode_flag = 0;
   logic [0:31] spr_wdata = '0, spr_rdata, rd_v;
   logic        spr_rvalid, priv_fault, cacheop_hit_eff;
   logic [0:18] par_in = '0;
   wire  [0:18] par_rec;
   logic        cacheop_mgmt = 0, cacheop_hit = 0, alt_timer_clock = 0;
   logic [0:3]  line_dirty = '0, line_dirty_eff, d_e;
   flush_size_t flush_size, sz_e;
   logic [63:0] cpu_timer, t0;
   int          n_mismatch = 0, checks = 0;
   always #4 clk = ~clk;
   core_config_parity_inject_reg core_config_parity_inject_reg_i (.clk, .rst,
      .spr_write, .spr_read, .spr_wdata, .user_mode_flag, .spr_rdata,
      .spr_rvalid, .priv_fault, .icache_word_par(par_in[0:7]),
      .icache_tag_par(par_in[8:9]), .dcache_tag_par(par_in[10:11]),
      .dcache_data_par(par_in[12]), .dcache_uattr_par(par_in[13]),
      .dcache_dirty_par(par_in[14]), .mmu_tag_par(par_in[15:18]),
      .icache_word_par_rec(par_rec[0:7]), .icache_tag_par_rec(par_rec[8:9]),
      .dcache_tag_par_rec(par_rec[10:11]), .dcache_data_par_rec(par_rec[12]),
      .dcache_uattr_par_rec(par_rec[13]), .dcache_dirty_par_rec(par_rec[14]),
      .mmu_tag_par_rec(par_rec[15:18]), .cacheop_mgmt, .cacheop_hit,
      .cacheop_hit_eff, .line_dirty, .line_dirty_eff, .flush_size,
      .alt_timer_clock, .cpu_timer);
   ////////////////////////////////////////////////////////////////////////
   task automatic wr(input logic [0:31] v);
      @(negedge clk) spr_write = 1;
      spr_wdata = v;
      @(negedge clk) spr_write = 0;
      `CHK("wr fault", user_mode_flag, priv_fault)
   endtask
   task automatic rd(output logic [0:31] v);
      @(negedge clk) spr_read = 1;
      @(negedge clk) spr_read = 0;
      v = spr_rdata;
      `CHK("rd valid", !user_mode_flag, spr_rvalid)
      `CHK("rd fault", user_mode_flag, priv_fault)
   endtask
   task automatic t_regs;
      wr(32'hFFFF_FFFF);
      rd(rd_v);
      `CHK("rdata", `CFG_WRITE_MASK, rd_v)
      user_mode_flag = 1;
      wr(32'h0000_0000);
      rd(rd_v);
      `CHK("user rdata", `CFG_WRITE_MASK, rd_v)
      user_mode_flag = 0;
      rd(rd_v);
      `CHK("kept", `CFG_WRITE_MASK, rd_v)
      $display("test regs done");
   endtask
   task automatic t_parity;
      logic [0:31] p;
      logic [0:18] pe;
      for (int i = 0; i < 3; i++) begin
         p = (i == 0) ? 32'h0 : (i == 1) ? 32'hFFFF_FFFF : 32'hA5C3_5A3C;
         wr(p);
         p = p & `CFG_WRITE_MASK;
         for (int j = 0; j < 2; j++) begin
            par_in = j ? 19'h7_FFFF : 19'h2_D2B1;
            pe = par_in ^ {p[0:14], p[16:19]};
            @(negedge clk);
            `CHK("ic par", pe[0:9], par_rec[0:9])
            `CHK("dc par", pe[10:13], par_rec[10:13])
            `CHK("mm par", pe[14:18], par_rec[14:18])
         end
      end
      $display("test parity done");
   endtask
   task automatic t_cache;
      logic h_e;
      for (int f = 0; f < 4; f++) begin
         // management ops here stand for block touches
         wr({15'h0, f[1], 4'h0, f[0], 11'h0});
         for (int d = 0; d < 16; d++) begin
            line_dirty = d[3:0];
            cacheop_mgmt = d[0];
            cacheop_hit = d[1];
            @(negedge clk);
            d_e = f[0] ? {4{d != 0}} : d[3:0];
            sz_e = (d_e == 0) ? FLUSH_NONE : ($countones(d_e) == 1) ?
               FLUSH_DWORD : (d_e[0:1] == 0 || d_e[2:3] == 0) ?
               FLUSH_QWORD : FLUSH_LINE;
            h_e = d[1] && !(d[0] && f[1]);
            `CHK("dirty", d_e, line_dirty_eff)
            `CHK("flush", sz_e, flush_size)
            `CHK("hit", h_e, cacheop_hit_eff)
         end
      end
      $display("test cache done");
   endtask
   task automatic t_timer;
      wr(32'h0000_0000);
      t0 = cpu_timer;
      repeat (10) @(negedge clk);
      `CHK("core ticks", t0 + 10, cpu_timer)
      wr(32'h0000_0080);
      t0 = cpu_timer;
      repeat (3) @(negedge clk);
      `CHK("held", t0, cpu_timer)
      // pin kept at a quarter of the core rate, inside the allowed limit
      repeat (5) begin
         alt_timer_clock = 1;
         repeat (2) @(negedge clk);
         alt_timer_clock = 0;
         repeat (2) @(negedge clk);
      end
      repeat (8) @(negedge clk);
      `CHK("alt ticks", t0 + 5, cpu_timer)
      // pin at exactly half the core rate, the fastest it may toggle
      t0 = cpu_timer;
      repeat (4) begin
         alt_timer_clock = 1;
         @(negedge clk);
         alt_timer_clock = 0;
         @(negedge clk);
      end
      repeat (8) @(negedge clk);
      `CHK("fast ticks", t0 + 4, cpu_timer)
      $display("test timer done");
   endtask
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   initial begin
      #20000;
      n_mismatch++;
      finish_test;
   end
   initial begin
      repeat (10) @(negedge clk);
      rst = 0;
      t_regs;
      t_parity;
      t_cache;
      t_timer;
      finish_test;
   end
endmodule
